// ---- rtl/sarc_pkg.sv ----
// Shared constants for the converter reset and abort control block.
package sarc_pkg;

	// ---------------------------------------------------------------
	// Clock and timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	localparam int ABORT_MAX_NS = 50;
	localparam int RESUME_MAX_NS = 20;
	localparam int ACQ_START_NS = 20;
	localparam int ACQ_TIME_NS = 150;
	localparam int CONV_TIME_NS = 650;
	localparam int SAMPLE_MIN_NS = 20;

	function automatic int ns_floor(input int ns);
		ns_floor = (ns / CLK_PERIOD_NS) < 1 ? 1 : ns / CLK_PERIOD_NS;
	endfunction : ns_floor

	function automatic int ns_ceil(input int ns);
		ns_ceil = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	endfunction : ns_ceil

	localparam int ABORT_CYC = ns_floor(ABORT_MAX_NS);
	localparam int RESUME_CYC = ns_floor(RESUME_MAX_NS);
	localparam int ACQ_START_CYC = ns_floor(ACQ_START_NS);
	localparam int ACQ_CYC = ns_ceil(ACQ_TIME_NS);
	localparam int CONV_CYC = ns_floor(CONV_TIME_NS);

	// ---------------------------------------------------------------
	// Data and counters
	// ---------------------------------------------------------------
	localparam int DATA_W = 16;
	localparam int CNT_W = 5;
	localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
	localparam int POR_CYC = 4;

	typedef enum logic [3:0] {
		SARC_RESET = 4'h1,
		SARC_ACQ = 4'h2,
		SARC_WAIT = 4'h4,
		SARC_CONV = 4'h8
	} sarc_state_e;

endpackage : sarc_pkg

// ---- rtl/sarc_sync.sv ----
// Two-flop synchroniser with falling-edge detect for the host pins.
module sarc_sync
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic pin_in,
	output logic level,
	output logic fall
);
	logic meta_q;
	logic sync_q;
	logic prev_q;

	// Pins idle high, so reset loads ones and no false edge follows release.
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			meta_q <= 1'b1;
			sync_q <= 1'b1;
			prev_q <= 1'b1;
		end
		else
		begin
			meta_q <= pin_in;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign level = sync_q;
	assign fall = prev_q & ~sync_q;
endmodule : sarc_sync

// ---- rtl/sarc_ctrl.sv ----
// Reset, abort and acquisition sequencing for the converter core.

// Operation
// [RL1] Reset pin is active low and acts whatever chip select is doing.
// [RL2] Host holds reset low at least 25 ns.
// [RL3] A reset aborts any running conversion within 50 ns; here busy drops on the third clock edge after the pin falls.
// [RL4] Reset clears the output data latch to all zeros.
// [RL5] Normal operation resumes within 20 ns after reset goes high; here in_reset falls on the third clock edge after the pin rises.
// [RL6] First acquisition starts 20 ns after reset release; here sampling rises on the third clock edge after the pin rises.
// [RL7] Later acquisitions start at the later of busy falling and select falling.
// [RL8] Start strobe falling with select low during conversion triggers internal reset.
// [RL9] Select falling during conversion triggers internal reset like the pin.
// [RL10] Strobe-triggered resets clear themselves without host action.
// [RL11] Host meets abort setup time for strobe-triggered aborts.
// [RL12] An internal power-on reset acts without any external pulse.
// [RL13] Host runs three conversions after power-up to clear registers.
// [RL14] Host starts conversion with start strobe low 20 ns while selected.
// [RL15] Busy rises on start, stays high through conversion, falls at end.
// [RL16] Any abort drops busy and never marks the partial result valid.
module sarc_ctrl
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic reset_n,
	input wire logic chip_select_n,
	input wire logic conversion_start_n,
	input wire logic [sarc_pkg::DATA_W-1:0] core_result,
	output logic busy,
	output logic sampling,
	output logic in_reset,
	output logic result_valid,
	output logic [sarc_pkg::DATA_W-1:0] result_data
);
	import sarc_pkg::*;

	logic rstn_lvl;
	logic cs_lvl;
	logic cs_fall;
	logic cst_fall;

	sarc_sync u_sync_rst
	(
		.clk_sys(clk_sys),
		.rst(rst),
		.pin_in(reset_n),
		.level(rstn_lvl),
		.fall()
	);

	sarc_sync u_sync_cs
	(
		.clk_sys(clk_sys),
		.rst(rst),
		.pin_in(chip_select_n),
		.level(cs_lvl),
		.fall(cs_fall)
	);

	sarc_sync u_sync_cst
	(
		.clk_sys(clk_sys),
		.rst(rst),
		.pin_in(conversion_start_n),
		.level(),
		.fall(cst_fall)
	);

	// ---------------------------------------------------------------
	// Shared decodes
	// ---------------------------------------------------------------
	// A start strobe only counts while select is already low.
	function automatic logic start_edge(input logic strobe_fall, input logic sel_n);
		start_edge = strobe_fall && !sel_n;
	endfunction : start_edge

	function automatic logic conv_last(input sarc_state_e st, input logic [CNT_W-1:0] cnt);
		conv_last = (st == SARC_CONV) && (cnt == 5'(CONV_CYC - 1));
	endfunction : conv_last

	// ---------------------------------------------------------------
	// Reset sources
	// ---------------------------------------------------------------
	sarc_state_e state_q;
	logic [CNT_W-1:0] cnt_q;
	logic [2:0] por_q;
	logic por_done;
	logic strobe_abort;
	logic pin_reset;
	logic any_reset;
	logic cs_seen_q;
	logic start_take;
	logic conv_done;
	logic reopen;
	logic clear_all;

	// The internal power-on counter holds the sequencer in reset for a few cycles.
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			por_q <= 3'h0; // RL12
		else if (!por_done)
			por_q <= por_q + 3'h1;
	end

	assign por_done = (por_q == 3'(POR_CYC));
	assign pin_reset = ~rstn_lvl; // RL1
	assign strobe_abort = (state_q == SARC_CONV) &&
		(cs_fall || start_edge(cst_fall, cs_lvl)); // RL8 RL9
	assign any_reset = pin_reset || !por_done;
	assign clear_all = any_reset || strobe_abort;
	assign start_take = (state_q == SARC_ACQ) && start_edge(cst_fall, cs_lvl);
	assign conv_done = conv_last(state_q, cnt_q);
	assign reopen = (state_q == SARC_WAIT) && (cs_fall || cs_seen_q || !cs_lvl);

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	// Strobe aborts pass through the same reset state as the pin, then leave it
	// on their own after the resume delay.
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			state_q <= SARC_RESET;
			cnt_q <= CNT_ZERO;
			cs_seen_q <= 1'b0;
		end
		else if (clear_all)
		begin
			state_q <= SARC_RESET; // RL3 RL10
			cnt_q <= CNT_ZERO;
			cs_seen_q <= 1'b0;
		end
		else
		begin
			case (state_q)
				SARC_RESET:
				begin
					cnt_q <= cnt_q + 5'h01;
					if (cnt_q == 5'(ACQ_START_CYC - 1))
					begin
						state_q <= SARC_ACQ; // RL5 RL6
						cnt_q <= CNT_ZERO;
					end
				end
				SARC_ACQ:
				begin
					if (cnt_q != 5'(ACQ_CYC))
						cnt_q <= cnt_q + 5'h01;
					if (start_take)
					begin
						state_q <= SARC_CONV; // RL15
						cnt_q <= CNT_ZERO;
					end
				end
				SARC_WAIT:
				begin
					if (cs_fall)
						cs_seen_q <= 1'b1;
					if (reopen)
					begin
						state_q <= SARC_ACQ; // RL7
						cnt_q <= CNT_ZERO;
					end
				end
				SARC_CONV:
				begin
					cnt_q <= cnt_q + 5'h01;
					if (conv_done)
					begin
						state_q <= SARC_WAIT; // RL15
						cnt_q <= CNT_ZERO;
						cs_seen_q <= 1'b0;
					end
				end
				default:
				begin
					state_q <= SARC_RESET;
					cnt_q <= CNT_ZERO;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (rst || clear_all)
			busy <= 1'b0; // RL16
		else if (start_take)
			busy <= 1'b1; // RL15
		else if (conv_done)
			busy <= 1'b0; // RL15
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst || clear_all)
			sampling <= 1'b0;
		else if (start_take)
			sampling <= 1'b0;
		else if (state_q == SARC_RESET && cnt_q == 5'(ACQ_START_CYC - 1))
			sampling <= 1'b1; // RL6
		else if (reopen)
			sampling <= 1'b1; // RL7
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			in_reset <= 1'b1;
		else
			in_reset <= clear_all ||
				(state_q == SARC_RESET && cnt_q != 5'(ACQ_START_CYC - 1));
	end

	// The result latch only loads at a completed conversion; aborts leave zeros.
	always_ff @(posedge clk_sys)
	begin
		if (rst || clear_all)
		begin
			result_data <= DATA_RST; // RL4
			result_valid <= 1'b0; // RL16
		end
		else if (conv_done)
		begin
			result_data <= core_result;
			result_valid <= 1'b1;
		end
		else if (start_take)
			result_valid <= 1'b0;
	end
endmodule : sarc_ctrl

// ---- verif/sarc_ctrl_sva.sv ----
// Port assertions for the converter reset and abort control.
module sarc_ctrl_sva
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic reset_n,
	input wire logic chip_select_n,
	input wire logic conversion_start_n,
	input wire logic busy,
	input wire logic sampling,
	input wire logic in_reset,
	input wire logic result_valid,
	input wire logic [15:0] result_data
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	property p_pin; $fell(reset_n) |-> ##[1:4] (in_reset && !busy); endproperty
	a_pin: assert property (p_pin) else $error("pin reset late");
	property p_cs; $fell(chip_select_n) && busy ##2 busy |-> ##[1:3] (in_reset && !busy);
	endproperty
	a_cs: assert property (p_cs) else $error("select abort missed");
	property p_st; $fell(conversion_start_n) && !chip_select_n && busy ##2 busy
		|-> ##[1:3] (in_reset && !busy);
	endproperty
	a_st: assert property (p_st) else $error("start abort missed");
	property p_clr; $fell(busy) && !result_valid |-> result_data == 16'h0000; endproperty
	a_clr: assert property (p_clr) else $error("result not cleared");
	property p_acq; $fell(in_reset) |-> sampling; endproperty
	a_acq: assert property (p_acq) else $error("no sampling after reset");
	property p_len; $fell(busy) && result_valid |-> $past(busy, 16) && !$past(busy, 17);
	endproperty
	a_len: assert property (p_len) else $error("busy length");
	property p_rise; $rose(busy) |-> !sampling && !result_valid && !in_reset; endproperty
	a_rise: assert property (p_rise) else $error("busy rise state");
	property p_seq; $rose(sampling) && !$past(in_reset) |-> !$past(chip_select_n, 3); endproperty
	a_seq: assert property (p_seq) else $error("sampling before select");
	property p_self; $rose(in_reset) && $past(reset_n) && $past(reset_n, 2) && $past(reset_n, 3)
		|-> ##1 (!in_reset && sampling); endproperty
	a_self: assert property (p_self) else $error("internal reset did not clear");
	c_done: cover property ($fell(busy) && result_valid);
	c_abort: cover property ($fell(busy) && in_reset);
	c_hold: cover property (busy ##1 !busy && !sampling);
endmodule : sarc_ctrl_sva

bind sarc_ctrl sarc_ctrl_sva chk_u
(
	.clk_sys(clk_sys),
	.rst(rst),
	.reset_n(reset_n),
	.chip_select_n(chip_select_n),
	.conversion_start_n(conversion_start_n),
	.busy(busy),
	.sampling(sampling),
	.in_reset(in_reset),
	.result_valid(result_valid),
	.result_data(result_data)
);

// ---- verif/sarc_host.sv ----
// Host model driving the reset, select and start pins.
module sarc_host
(
	input wire logic clk_sys,
	output logic reset_n,
	output logic chip_select_n,
	output logic conversion_start_n
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		reset_n = 1'b1;
		chip_select_n = 1'b1;
		conversion_start_n = 1'b1;
	end
	task automatic set_cs(input logic v);
		@(negedge clk_sys);
		chip_select_n = v;
	endtask : set_cs
	// One low cycle is 40 ns, so both minimum widths are met.
	task automatic start();
		set_cs(1'b0);
		@(negedge clk_sys);
		conversion_start_n = 1'b0;
		@(negedge clk_sys);
		conversion_start_n = 1'b1;
	endtask : start
	task automatic pin_reset();
		@(negedge clk_sys);
		reset_n = 1'b0;
		@(negedge clk_sys);
		reset_n = 1'b1;
	endtask : pin_reset
endmodule : sarc_host

// ---- verif/sar_adc_reset_abort_control_tb.sv ----
// Self-checking bench for the converter reset and abort control.
module sar_adc_reset_abort_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import sarc_pkg::*;
	logic clk_sys, rst, reset_n, chip_select_n, conversion_start_n;
	logic busy, sampling, in_reset, result_valid;
	logic [DATA_W-1:0] core_result, result_data;
	int err_total = 0;
	int cmp_count = 0;
	int cyc = 0;
	int mode;
	sarc_host host_u
	(
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.chip_select_n(chip_select_n),
		.conversion_start_n(conversion_start_n)
	);
	sarc_ctrl dut_u
	(
		.clk_sys(clk_sys),
		.rst(rst),
		.reset_n(reset_n),
		.chip_select_n(chip_select_n),
		.conversion_start_n(conversion_start_n),
		.core_result(core_result),
		.busy(busy),
		.sampling(sampling),
		.in_reset(in_reset),
		.result_valid(result_valid),
		.result_data(result_data)
	);
	initial
	begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	task automatic report_and_stop();
		if (err_total == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : report_and_stop
	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			err_total++;
			report_and_stop();
		end
	end
	// Only a completed conversion may carry the core's word.
	function automatic logic [DATA_W-1:0] expect_word(input int m, input logic [DATA_W-1:0] w);
		return (m == 0 || m == 4) ? w : 16'h0000;
	endfunction : expect_word
	// Select, second start and pin reset all abort the running conversion.
	function automatic logic expect_abort(input int m);
		return m >= 1 && m <= 3;
	endfunction : expect_abort
	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_bit(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_bit
	task automatic wait_on(input int w);
		for (int i = 0; i < 40; i++)
		begin
			@(negedge clk_sys);
			if ((w == 0 ? sampling : busy) === (w != 2))
				break;
		end
		chk_bit(w == 0 ? sampling : busy, w != 2);
	endtask : wait_on
	initial
	begin
		void'($urandom(38147));
		rst = 1'b1;
		core_result = 16'h0000;
		repeat (5) @(negedge clk_sys);
		rst = 1'b0;
		wait_on(0);
		for (int n = 0; n < 20; n++)
		begin
			mode = n < 3 ? 0 : n < 8 ? n - 3 : $urandom_range(4, 0);
			core_result = n == 0 ? 16'hffff : 16'($urandom);
			host_u.start();
			wait_on(1);
			repeat (3) @(negedge clk_sys);
			if (mode == 1 || mode >= 3)
				host_u.set_cs(1'b1);
			if (mode == 1)
				host_u.set_cs(1'b0);
			if (mode == 2)
				host_u.start();
			if (mode == 3)
				host_u.pin_reset();
			wait_on(2);
			chk_bit(in_reset, expect_abort(mode));
			@(negedge clk_sys);
			chk(result_data, expect_word(mode, core_result));
			chk_bit(result_valid, mode == 0 || mode == 4);
			repeat (4) @(negedge clk_sys);
			chk_bit(sampling, mode != 4);
			host_u.set_cs(1'b0);
			wait_on(0);
		end
		report_and_stop();
	end
endmodule : sar_adc_reset_abort_control_tb
